// file: verilog/cer_params.svh
// Constants for the comparator event and ladder reference block.
// Assumes a 32-bit AHB-Lite slave; each register sits in one aligned word.
`ifndef CER_PARAMS_SVH
`define CER_PARAMS_SVH
// Byte offsets
`define CER_OFS_CMP1 8'h00
`define CER_OFS_CMP2 8'h04
`define CER_OFS_STAT 8'h08
`define CER_OFS_FLAGS 8'h0c
`define CER_OFS_IEN 8'h10
`define CER_OFS_IPRI 8'h14
`define CER_OFS_SHARED 8'h18
`define CER_OFS_WDT 8'h1c
`define CER_OFS_SYS 8'h20
// Comparator settings fields
`define CER_CFG_EN 7
`define CER_CFG_PIN 6
`define CER_CFG_INV 5
`define CER_CFG_EDGE_HI 4
`define CER_CFG_EDGE_LO 3
`define CER_CFG_REF 2
`define CER_CFG_CH_HI 1
`define CER_CFG_CH_LO 0
// Interrupt flag, enable and priority positions
`define CER_BIT_CMP1_IRQ 5
`define CER_BIT_CMP2_IRQ 6
// Ladder settings fields
`define CER_LAD_EN 7
`define CER_LAD_OE 6
`define CER_LAD_RANGE 5
`define CER_LAD_SRC 4
`define CER_LAD_LVL_HI 3
`define CER_LAD_LVL_LO 0
// Bank select in watchdog settings
`define CER_WDT_BANK 4
// System control fields
`define CER_SYS_GIE 7
`define CER_SYS_PERIPHERAL_IRQ_ENABLE 6
`define CER_SYS_DIR5 5
// Reset values
`define CER_RST_CMP 8'h00
`define CER_RST_LAD 8'h00
`define CER_RST_TMR 8'hff
`define CER_RST_SYS 8'h20
// High range starts a quarter up: 8 steps of 1/32
`define CER_HI_RANGE_BASE 5'h08
`define CER_WORD_SIZE 3'h2
`endif

// file: verilog/cer_pkg.sv
// Types shared by the comparator event and ladder reference block.
// Assumes the constants header is included by the design file.
`default_nettype none
package cer_pkg;
  typedef enum logic [1:0] {
    CER_EDGE_NONE,
    CER_EDGE_RISE,
    CER_EDGE_FALL,
    CER_EDGE_BOTH
  } cer_edge_t;
endpackage
`default_nettype wire

// file: verilog/cer_top.sv
// Comparator event logic, interrupt bits and ladder reference settings.
// Assumes a single AHB-Lite master and asynchronous comparator outputs.
//
// The AHB-Lite interface to the registers and the register offsets are this design's own decisions.
`include "cer_params.svh"
`default_nettype none

// Overview of operation
// - Edge select 00 none, 01 rising, 10 falling, 11 both, after polarity.
// - Enabled comparators keep running and flagging during Sleep.
// - An enabled comparator interrupt wakes the device from Sleep.
// - Comparator settings survive Sleep and wake unchanged.
// - Reset returns both comparator settings to reset, all off.
// - Settings: enable, pin out, invert, edge select, plus ref, minus channel.
// - Comparator 2 flag at bit 6, comparator 1 flag at bit 5.
// - Comparator 2 and 1 enables at bits 6 and 5.
// - Comparator 2 and 1 priorities at bits 6 and 5.
// - Ladder: enable, pin out, range, source, 4-bit level; all RW, reset 0.
// - Range 1 gives level/24 from zero; range 0 gives 1/4 plus level/32.
// - Level 0 to 15 picks one of sixteen taps within the range.
// - Ladder register shares timer period address; reached only with bank bit.
// - Ladder pin output overrides port F bit 5 direction.
// - Ladder settings survive Sleep and wake unchanged.
// - Reset clears ladder enable, pin out, range and level.
// - Flags stay set until cleared; writing 1 sets a flag.
// - Interrupt needs enable, peripheral and global enables; flag sets anyway.
// - Status bit 0 is comparator 1 output, bit 1 comparator 2.
// - Invert applies to reported level, pin output and edge detection.
module cer_top
  import cer_pkg::*;
#(
  parameter int NUM_CMP = 2
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Analog comparators
  input wire logic [NUM_CMP-1:0] cmp_raw,
  output logic [NUM_CMP-1:0] cmp_power_on,
  output logic [NUM_CMP-1:0] plus_input_ref_select,
  output logic [2*NUM_CMP-1:0] minus_input_select,
  output logic [NUM_CMP-1:0] cmp_pin_drive_enable,
  output logic [NUM_CMP-1:0] cmp_pin_level,
  // Ladder reference
  output logic ladder_power_enable,
  output logic ladder_source_select,
  output logic ladder_step_div24,
  output logic [4:0] ladder_tap,
  output logic ladder_pin_drive,
  output logic port_f5_digital_oe,
  output logic [7:0] timer_period_reg,
  // Power and interrupts
  input wire logic sleep_mode,
  output logic wake_req,
  output logic cmp_irq_high,
  output logic cmp_irq_low
);

  // Bus tracking
  logic wr_q, rd_q, hreadyout_q;
  logic [7:0] addr_q;
  logic [31:0] hrdata_q;
  logic [31:0] rdata;
  // Registers
  logic [7:0] cfg_q [NUM_CMP];
  logic [NUM_CMP-1:0] flag_q, ien_q, ipri_q;
  logic [7:0] lad_q, tmr_q, sys_q;
  logic bank_q;
  // Comparator pipeline
  logic [NUM_CMP-1:0] s1_q, s2_q, prev_q, lvl, ev;
  // Output flops
  logic wake_q, irq_hi_q, irq_lo_q, lad_drive_q, f5_oe_q;
  logic [4:0] tap_q;
  logic [NUM_CMP-1:0] pin_en_q, pin_lvl_q, pwr_q, pref_q;
  logic [2*NUM_CMP-1:0] minus_q;
  logic lad_en_q, lad_src_q, lad_div_q;

  wire addr_phase = hsel && hready && htrans[1];
  wire word_ok = (hsize == `CER_WORD_SIZE);
  wire sel_flags = (addr_q == `CER_OFS_FLAGS);
  wire sel_ien = (addr_q == `CER_OFS_IEN);
  wire sel_ipri = (addr_q == `CER_OFS_IPRI);
  wire sel_shared = (addr_q == `CER_OFS_SHARED);
  wire sel_wdt = (addr_q == `CER_OFS_WDT);
  wire sel_sys = (addr_q == `CER_OFS_SYS);
  wire sel_stat = (addr_q == `CER_OFS_STAT);
  wire wr_flags = wr_q && sel_flags;
  wire wr_lad = wr_q && sel_shared && bank_q;
  wire wr_tmr = wr_q && sel_shared && !bank_q;
  wire [NUM_CMP-1:0] pend = flag_q & ien_q;
  wire gate = sys_q[`CER_SYS_GIE] && sys_q[`CER_SYS_PERIPHERAL_IRQ_ENABLE];
  wire [NUM_CMP-1:0] flag_wdata =
    hwdata[`CER_BIT_CMP1_IRQ+NUM_CMP-1:`CER_BIT_CMP1_IRQ];

  // Writes land in the data phase; reads take one wait state so that a
  // write just before a read to the same word is always seen.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 8'h00;
      hreadyout_q <= 1'b1;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wr_q <= addr_phase && hwrite && word_ok;
      rd_q <= addr_phase && !hwrite;
      if (addr_phase) begin
        addr_q <= haddr[7:0];
      end
      hreadyout_q <= !(addr_phase && !hwrite);
      if (rd_q) begin
        hrdata_q <= rdata;
      end
    end
  end

  always_comb begin
    rdata = 32'h0000_0000;
    if (addr_q == `CER_OFS_CMP1) begin
      rdata[7:0] = cfg_q[0];
    end else if (addr_q == `CER_OFS_CMP2) begin
      rdata[7:0] = cfg_q[1];
    end else if (sel_stat) begin
      rdata[NUM_CMP-1:0] = lvl;
    end else if (sel_flags) begin
      rdata[`CER_BIT_CMP1_IRQ+NUM_CMP-1:`CER_BIT_CMP1_IRQ] = flag_q;
    end else if (sel_ien) begin
      rdata[`CER_BIT_CMP1_IRQ+NUM_CMP-1:`CER_BIT_CMP1_IRQ] = ien_q;
    end else if (sel_ipri) begin
      rdata[`CER_BIT_CMP1_IRQ+NUM_CMP-1:`CER_BIT_CMP1_IRQ] = ipri_q;
    end else if (sel_shared) begin
      rdata[7:0] = bank_q ? lad_q : tmr_q;
    end else if (sel_wdt) begin
      rdata[`CER_WDT_BANK] = bank_q;
    end else if (sel_sys) begin
      rdata[7:0] = sys_q;
    end
  end

  // Per-comparator settings, synchroniser, polarity, edge detect and flag
  for (genvar i = 0; i < NUM_CMP; i++) begin : g_cmp
    wire wr_cfg = wr_q && (addr_q == (`CER_OFS_CMP1 + 8'(4 * i)));
    wire en = cfg_q[i][`CER_CFG_EN];
    wire [1:0] esel = cfg_q[i][`CER_CFG_EDGE_HI:`CER_CFG_EDGE_LO];
    wire rise = lvl[i] && !prev_q[i];
    wire fall = !lvl[i] && prev_q[i];
    // Disabled comparator reads low; switching it off while high can flag a falling edge
    assign lvl[i] = en && (s2_q[i] ^ cfg_q[i][`CER_CFG_INV]);
    assign ev[i] = ((esel == CER_EDGE_RISE) && rise)
                || ((esel == CER_EDGE_FALL) && fall)
                || ((esel == CER_EDGE_BOTH) && (rise || fall));

    // Sleep never touches these; only reset and software do
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        cfg_q[i] <= `CER_RST_CMP;
      end else if (wr_cfg) begin
        cfg_q[i] <= hwdata[7:0];
      end
    end

    // Second stage alone reads the first
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        s1_q[i] <= 1'b0;
        s2_q[i] <= 1'b0;
        prev_q[i] <= 1'b0;
      end else begin
        s1_q[i] <= cmp_raw[i];
        s2_q[i] <= s1_q[i];
        prev_q[i] <= lvl[i];
      end
    end

    // Hardware set wins over a software clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        flag_q[i] <= 1'b0;
      end else if (ev[i]) begin
        flag_q[i] <= 1'b1;
      end else if (wr_flags) begin
        flag_q[i] <= flag_wdata[i];
      end
    end
  end

  // Enables, priorities, bank select, system bits, ladder
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ien_q <= '0;
      ipri_q <= '0;
      bank_q <= 1'b0;
      sys_q <= `CER_RST_SYS;
      lad_q <= `CER_RST_LAD;
      tmr_q <= `CER_RST_TMR;
    end else begin
      if (wr_q && sel_ien) begin
        ien_q <= flag_wdata;
      end
      if (wr_q && sel_ipri) begin
        ipri_q <= flag_wdata;
      end
      if (wr_q && sel_wdt) begin
        bank_q <= hwdata[`CER_WDT_BANK];
      end
      if (wr_q && sel_sys) begin
        sys_q <= {hwdata[7:5], 5'h00};
      end
      if (wr_lad) begin
        lad_q <= hwdata[7:0];
      end
      if (wr_tmr) begin
        tmr_q <= hwdata[7:0];
      end
    end
  end

  // Output stage; every port but hresp is a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_q <= 1'b0;
      irq_hi_q <= 1'b0;
      irq_lo_q <= 1'b0;
      lad_drive_q <= 1'b0;
      f5_oe_q <= 1'b0;
      tap_q <= `CER_HI_RANGE_BASE;
      lad_en_q <= 1'b0;
      lad_src_q <= 1'b0;
      lad_div_q <= 1'b0;
    end else begin
      wake_q <= sleep_mode && (|pend);
      irq_hi_q <= gate && (|(pend & ipri_q));
      irq_lo_q <= gate && (|(pend & ~ipri_q));
      lad_drive_q <= lad_q[`CER_LAD_OE];
      f5_oe_q <= !lad_q[`CER_LAD_OE] && !sys_q[`CER_SYS_DIR5];
      lad_en_q <= lad_q[`CER_LAD_EN];
      lad_src_q <= lad_q[`CER_LAD_SRC];
      lad_div_q <= lad_q[`CER_LAD_RANGE];
      // Tap in steps of the chosen denominator
      tap_q <= (lad_q[`CER_LAD_RANGE] ? 5'h00 : `CER_HI_RANGE_BASE)
             + {1'b0, lad_q[`CER_LAD_LVL_HI:`CER_LAD_LVL_LO]};
    end
  end

  for (genvar i = 0; i < NUM_CMP; i++) begin : g_out
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        pin_en_q[i] <= 1'b0;
        pin_lvl_q[i] <= 1'b0;
        pwr_q[i] <= 1'b0;
        pref_q[i] <= 1'b0;
        minus_q[2*i+1:2*i] <= 2'h0;
      end else begin
        pin_en_q[i] <= cfg_q[i][`CER_CFG_PIN];
        pin_lvl_q[i] <= lvl[i];
        pwr_q[i] <= cfg_q[i][`CER_CFG_EN];
        pref_q[i] <= cfg_q[i][`CER_CFG_REF];
        minus_q[2*i+1:2*i] <= cfg_q[i][`CER_CFG_CH_HI:`CER_CFG_CH_LO];
      end
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;
  assign cmp_power_on = pwr_q;
  assign plus_input_ref_select = pref_q;
  assign minus_input_select = minus_q;
  assign cmp_pin_drive_enable = pin_en_q;
  assign cmp_pin_level = pin_lvl_q;
  assign ladder_power_enable = lad_en_q;
  assign ladder_source_select = lad_src_q;
  assign ladder_step_div24 = lad_div_q;
  assign ladder_tap = tap_q;
  assign ladder_pin_drive = lad_drive_q;
  assign port_f5_digital_oe = f5_oe_q;
  assign timer_period_reg = tmr_q;
  assign wake_req = wake_q;
  assign cmp_irq_high = irq_hi_q;
  assign cmp_irq_low = irq_lo_q;

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_rise_sets;
    $rose(lvl[0]) && (cfg_q[0][4:3] == CER_EDGE_RISE) |=> flag_q[0];
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("rise lost");

  property p_none_quiet;
    (cfg_q[1][4:3] == CER_EDGE_NONE) |-> !ev[1];
  endproperty
  a_none_quiet: assert property (p_none_quiet) else $error("event with none");

  property p_flag_holds;
    flag_q[1] && !wr_flags |=> flag_q[1];
  endproperty
  a_flag_holds: assert property (p_flag_holds) else $error("flag dropped");

  property p_sw_set;
    wr_flags && hwdata[`CER_BIT_CMP1_IRQ] |=> flag_q[0];
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("soft set lost");

  property p_wake;
    sleep_mode && (flag_q[0] && ien_q[0]) |=> wake_req;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");

  property p_irq_gate;
    (cmp_irq_high || cmp_irq_low) |-> $past(gate) && $past(|pend);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("ungated irq");

  property p_sync;
    cfg_q[0][`CER_CFG_EN] && ($past(cfg_q[0]) == cfg_q[0])
      && ($past(cfg_q[0], 2) == cfg_q[0])
      |-> lvl[0] == ($past(cmp_raw[0], 2) ^ cfg_q[0][`CER_CFG_INV]);
  endproperty
  a_sync: assert property (p_sync) else $error("sync path wrong");

  property p_override;
    lad_q[`CER_LAD_OE] |=> ladder_pin_drive && !port_f5_digital_oe;
  endproperty
  a_override: assert property (p_override) else $error("pin override");

  property p_bank;
    wr_q && sel_shared && !bank_q |=> $stable(lad_q);
  endproperty
  a_bank: assert property (p_bank) else $error("bank leak");

  property p_range;
    !lad_q[`CER_LAD_RANGE] |=> ladder_tap == 5'(8 + $past(lad_q[3:0]));
  endproperty
  a_range: assert property (p_range) else $error("high range tap");

  c_both: cover property ((cfg_q[0][4:3] == CER_EDGE_BOTH) && ev[0]);
  c_wake: cover property (wake_req);
  c_lad_wr: cover property (wr_lad);
  c_irq: cover property (cmp_irq_high);

endmodule // cer_top
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the comparator event and ladder reference block.
// Assumes the design's AHB-Lite slave is the only slave on the bus.
`include "cer_params.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp;
  logic [1:0] cmp_raw = 2'h0;
  logic [1:0] cmp_power_on, plus_ref, pin_en, pin_lvl;
  logic [3:0] minus_sel;
  logic lad_en, lad_src, lad_div24, lad_pin, f5_oe;
  logic [4:0] lad_tap;
  logic [7:0] tmr;
  logic sleep_mode = 1'b0;
  logic wake_req, irq_hi, irq_lo;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  cer_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cmp_raw(cmp_raw), .cmp_power_on(cmp_power_on),
    .plus_input_ref_select(plus_ref), .minus_input_select(minus_sel),
    .cmp_pin_drive_enable(pin_en), .cmp_pin_level(pin_lvl), .ladder_power_enable(lad_en),
    .ladder_source_select(lad_src), .ladder_step_div24(lad_div24), .ladder_tap(lad_tap),
    .ladder_pin_drive(lad_pin), .port_f5_digital_oe(f5_oe), .timer_period_reg(tmr),
    .sleep_mode(sleep_mode), .wake_req(wake_req), .cmp_irq_high(irq_hi), .cmp_irq_low(irq_lo));
  initial begin
    forever #5 hclk = ~hclk;
  end
  task automatic stop_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Hang guard, well above the few hundred cycles the scenarios need
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      stop_test;
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Entered and left right after a rising edge; waits on hready, never counts
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string name);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(name, e, r);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic t_reset;
    rd(`CER_OFS_CMP1, 32'h0, "cmp1_rst");
    rd(`CER_OFS_CMP2, 32'h0, "cmp2_rst");
    rd(`CER_OFS_SHARED, 32'hff, "timer_rst");
    wr(`CER_OFS_WDT, 32'h10);
    rd(`CER_OFS_SHARED, 32'h0, "ladder_rst");
    wr(`CER_OFS_WDT, 32'h0);
    rd(8'h40, 32'h0, "unmapped");
    chk("hresp", 32'h0, {31'h0, hresp});
    chk("tap_rst", 32'h8, {27'h0, lad_tap});
    chk("power_rst", 32'h0, {29'h0, lad_en, cmp_power_on});
  endtask
  // Every edge mode on both comparators, both directions
  task automatic t_edges;
    for (int c = 0; c < 2; c++) begin
      for (int e = 0; e < 4; e++) begin
        wr(`CER_OFS_CMP1 + 8'(4 * c), 32'h80 | 32'(e << 3));
        wr(`CER_OFS_FLAGS, 32'h0);
        cmp_raw[c] <= 1'b1;
        wt(5);
        rd(`CER_OFS_FLAGS, (e % 2 == 1) ? 32'h20 << c : 32'h0, "flag_rise");
        wr(`CER_OFS_FLAGS, 32'h0);
        cmp_raw[c] <= 1'b0;
        wt(5);
        rd(`CER_OFS_FLAGS, (e > 1) ? 32'h20 << c : 32'h0, "flag_fall");
      end
      wr(`CER_OFS_CMP1 + 8'(4 * c), 32'h0);
    end
  endtask
  task automatic t_layout;
    wr(`CER_OFS_FLAGS, 32'h0);
    wr(`CER_OFS_CMP1, 32'ha7);
    wr(`CER_OFS_CMP2, 32'h46);
    wt(3);
    chk("cmp_fields", 32'h1eb, {22'h0, cmp_power_on, plus_ref, pin_en, minus_sel});
    chk("pin_inv", 32'h1, {30'h0, pin_lvl});
    rd(`CER_OFS_STAT, 32'h1, "stat_inv");
    cmp_raw <= 2'h1;
    wt(4);
    rd(`CER_OFS_STAT, 32'h0, "stat_hi");
    rd(`CER_OFS_FLAGS, 32'h0, "edge_none");
    cmp_raw <= 2'h0;
    wr(`CER_OFS_CMP1, 32'h80);
    wr(`CER_OFS_CMP2, 32'h80);
    cmp_raw <= 2'h2;
    wt(4);
    rd(`CER_OFS_STAT, 32'h2, "stat_cmp2");
    cmp_raw <= 2'h0;
    wr(`CER_OFS_CMP2, 32'h0);
  endtask
  task automatic t_irq;
    wr(`CER_OFS_FLAGS, 32'h0);
    wr(`CER_OFS_IEN, 32'h60);
    wr(`CER_OFS_IPRI, 32'h20);
    wr(`CER_OFS_SYS, 32'he0);
    rd(`CER_OFS_IEN, 32'h60, "ien");
    rd(`CER_OFS_IPRI, 32'h20, "ipri");
    wr(`CER_OFS_FLAGS, 32'h60);
    wt(3);
    chk("irq_split", 32'h3, {30'h0, irq_hi, irq_lo});
    wr(`CER_OFS_SYS, 32'h60);
    wt(3);
    chk("irq_gie_off", 32'h0, {30'h0, irq_hi, irq_lo});
    rd(`CER_OFS_FLAGS, 32'h60, "flag_kept");
    wr(`CER_OFS_FLAGS, 32'h0);
  endtask
  // Comparator left on across one Sleep, then off across a second Sleep, as software may choose
  task automatic t_sleep;
    wr(`CER_OFS_CMP1, 32'h88);
    wr(`CER_OFS_IEN, 32'h20);
    sleep_mode <= 1'b1;
    wt(3);
    chk("no_wake", 32'h0, {31'h0, wake_req});
    cmp_raw <= 2'h1;
    wt(6);
    chk("wake", 32'h1, {31'h0, wake_req});
    rd(`CER_OFS_FLAGS, 32'h20, "sleep_flag");
    sleep_mode <= 1'b0;
    rd(`CER_OFS_CMP1, 32'h88, "cmp1_kept");
    wr(`CER_OFS_CMP1, 32'h08);
    sleep_mode <= 1'b1;
    wt(2);
    chk("sleep_off", 32'h0, {30'h0, cmp_power_on});
    rd(`CER_OFS_CMP1, 32'h08, "cmp1_off_kept");
    sleep_mode <= 1'b0;
  endtask
  task automatic t_ladder;
    wr(`CER_OFS_SYS, 32'h0);
    wr(`CER_OFS_WDT, 32'h10);
    wr(`CER_OFS_SHARED, 32'he5);
    wt(3);
    chk("lad_lo", 32'h1c5, {23'h0, lad_en, lad_pin, lad_div24, lad_src, lad_tap});
    chk("f5_over", 32'h0, {31'h0, f5_oe});
    wr(`CER_OFS_SHARED, 32'h1f);
    wt(3);
    chk("lad_hi", 32'h37, {23'h0, lad_en, lad_pin, lad_div24, lad_src, lad_tap});
    chk("f5_free", 32'h1, {31'h0, f5_oe});
    wr(`CER_OFS_WDT, 32'h0);
    wr(`CER_OFS_SHARED, 32'h33);
    wt(2);
    chk("timer", 32'h33, {24'h0, tmr});
    wr(`CER_OFS_WDT, 32'h10);
    rd(`CER_OFS_SHARED, 32'h1f, "lad_kept");
    wr(`CER_OFS_SHARED, 32'hff);
    hresetn <= 1'b0;
    wt(2);
    hresetn <= 1'b1;
    wt(1);
    wr(`CER_OFS_WDT, 32'h10);
    rd(`CER_OFS_SHARED, 32'h0, "lad_rst2");
    rd(`CER_OFS_CMP1, 32'h0, "cmp1_rst2");
  endtask
  initial begin
    wt(16);
    hresetn <= 1'b1;
    wt(1);
    t_reset;
    t_edges;
    t_layout;
    t_irq;
    t_sleep;
    t_ladder;
    stop_test;
  end
endmodule // tb_top
`default_nettype wire
